// ==== evc_ctrl.sv ====
// Summary of operation
// R1 - 8-bit result, 15.3 mV per code
// R2 - Start bit launches single conversion, then interrupt
// R3 - Background off until interval field nonzero
// R4 - Background change above delta sets flag
// R5 - Enable bit routes change flag to interrupt
// R6 - Full power: single and background allowed
// R7 - Battery active: single only, no background
// R8 - Deep sleep: background conversions only
// R9 - Result loads only on interrupt
// R10 - Interrupt on big change or single done
// R11 - Software: single, then delta, then interval
// R12 - Keep reference of last interrupting result
`timescale 1ns/1ps
`default_nettype none

module evc_ctrl #(
    parameter int unsigned UNIT_CYCLES = evc_pkg::STROBE_UNIT_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic nrst_i, // Sync reset, active low
    input wire evc_pkg::evc_sfr_req_t sfr_req_i, // Register access
    output logic [7:0] sfr_rdata_o, // Read data, one cycle late
    input wire evc_pkg::evc_pwr_state_t pwr_state_i, // Power state
    output logic conv_start_o, // Start pulse to converter
    input wire evc_pkg::evc_conv_t conv_i, // Converter done and data
    output logic adc_irq_o, // ADC interrupt pulse
    output logic psm_irq_o // Power management interrupt level
);
    localparam int DW = evc_pkg::DATA_W;

    typedef enum logic {ST_IDLE, ST_BUSY} evc_state_t;

    function automatic logic [DW-1:0] abs_diff(input logic [DW-1:0] a,
                                               input logic [DW-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    evc_state_t state_r;
    logic go_r, bg_r, pend_r, flag_r, en_r;
    logic [evc_pkg::INTERVAL_W-1:0] interval_r;
    logic [evc_pkg::DELTA_W-1:0] delta_r;
    logic [DW-1:0] result_r, ref_r, rdata_r;
    logic start_r, adc_irq_r, psm_irq_r;
    logic tick;

    // ********************************************************
    // Decode
    // ********************************************************
    wire [7:0] wd = sfr_req_i.wdata;
    wire wr_start = sfr_req_i.wr && sfr_req_i.addr == evc_pkg::ADDR_START;
    wire wr_delta = sfr_req_i.wr && sfr_req_i.addr == evc_pkg::ADDR_DELTA;
    wire wr_flag = sfr_req_i.wr && sfr_req_i.addr == evc_pkg::ADDR_PM_FLAG;
    wire wr_en = sfr_req_i.wr && sfr_req_i.addr == evc_pkg::ADDR_PM_EN;
    wire wr_strobe = sfr_req_i.wr && sfr_req_i.addr == evc_pkg::ADDR_STROBE;

    wire full_pwr = pwr_state_i == evc_pkg::FULL_POWER_STATE;
    wire batt_act = pwr_state_i == evc_pkg::BATTERY_ACTIVE_STATE;
    wire deep_slp = pwr_state_i == evc_pkg::DEEP_SLEEP_STATE;

    // Processor halted in deep sleep, so no single starts there
    wire single_ok = full_pwr || batt_act; // [R6] [R7] [R8]
    wire bg_ok = (interval_r != evc_pkg::INTERVAL_OFF)
                 && (full_pwr || deep_slp); // [R3] [R6] [R7] [R8]

    wire go_req = wr_start && wd[evc_pkg::GO_BIT] && single_ok; // [R2]
    wire idle = state_r == ST_IDLE;
    // A start left pending from before deep sleep waits there
    wire launch_single = idle && go_r && single_ok; // [R8]
    // Single start has priority over a pending background strobe
    wire launch_bg = idle && !launch_single && pend_r && bg_ok;
    wire launch = launch_single || launch_bg;

    wire done = state_r == ST_BUSY && conv_i.done;
    wire diff_big = abs_diff(conv_i.data, ref_r)
                    > DW'(delta_r); // [R4]
    wire bg_change = done && bg_r && diff_big; // [R4]
    wire hit = done && (!bg_r || diff_big); // [R10]

    // Set wins over a same-cycle software clear
    wire flag_nxt = bg_change
                    || (flag_r && !(wr_flag && !wd[evc_pkg::CHANGE_BIT]));
    wire go_nxt = go_req || (go_r && !launch_single);
    wire pend_nxt = bg_ok && (tick || (pend_r && !launch_bg));
    wire bg_nxt = launch ? launch_bg : bg_r;
    wire [7:0] interval_byte = 8'(interval_r) << evc_pkg::INTERVAL_LSB;
    wire [7:0] rd_mux =
        (sfr_req_i.addr == evc_pkg::ADDR_RESULT) ? result_r :
        (sfr_req_i.addr == evc_pkg::ADDR_START) ? 8'(go_r) << evc_pkg::GO_BIT :
        (sfr_req_i.addr == evc_pkg::ADDR_DELTA) ? 8'(delta_r) :
        (sfr_req_i.addr == evc_pkg::ADDR_PM_FLAG) ?
            8'(flag_r) << evc_pkg::CHANGE_BIT :
        (sfr_req_i.addr == evc_pkg::ADDR_PM_EN) ?
            8'(en_r) << evc_pkg::CHANGE_BIT :
        (sfr_req_i.addr == evc_pkg::ADDR_STROBE) ? interval_byte : 8'h00;

    // ********************************************************
    // Strobe timer
    // ********************************************************
    evc_strobe_timer #(.UNIT_CYCLES(UNIT_CYCLES)) evc_strobe_timer_inst (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .interval_i(interval_r),
        .tick_o(tick)
    );

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            go_r <= 1'h0;
            bg_r <= 1'h0;
            pend_r <= 1'h0;
            start_r <= 1'h0;
        end else begin
            state_r <= launch ? ST_BUSY : (done ? ST_IDLE : state_r);
            go_r <= go_nxt; // [R2]
            bg_r <= bg_nxt;
            pend_r <= pend_nxt; // [R3]
            start_r <= launch;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            interval_r <= evc_pkg::INTERVAL_OFF; // [R3]
            delta_r <= evc_pkg::DELTA_RST;
            en_r <= 1'h0;
            flag_r <= 1'h0;
        end else begin
            if (wr_strobe) begin
                interval_r <= wd[evc_pkg::INTERVAL_LSB +: evc_pkg::INTERVAL_W];
            end
            if (wr_delta) begin
                delta_r <= wd[evc_pkg::DELTA_LSB +: evc_pkg::DELTA_W];
            end
            if (wr_en) begin
                en_r <= wd[evc_pkg::CHANGE_BIT];
            end
            flag_r <= flag_nxt; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            result_r <= evc_pkg::RESULT_RST;
            ref_r <= evc_pkg::RESULT_RST;
            adc_irq_r <= 1'h0;
            psm_irq_r <= 1'h0;
            rdata_r <= 8'h00;
        end else begin
            if (hit) begin
                result_r <= conv_i.data; // [R1] [R9]
                ref_r <= conv_i.data; // [R12]
            end
            adc_irq_r <= hit; // [R2] [R10]
            psm_irq_r <= flag_r && en_r; // [R5]
            rdata_r <= rd_mux;
        end
    end

    assign sfr_rdata_o = rdata_r;
    assign conv_start_o = start_r;
    assign adc_irq_o = adc_irq_r;
    assign psm_irq_o = psm_irq_r;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_single_done;
        state_r == ST_BUSY && !bg_r && conv_i.done;
    endsequence

    sequence s_bg_change;
        state_r == ST_BUSY && bg_r && conv_i.done && diff_big;
    endsequence

    chk_result_on_irq: assert property ( // [R9]
        $changed(result_r) |-> adc_irq_r)
        else $error("result changed without interrupt");

    chk_single_irq: assert property ( // [R2]
        s_single_done |=> adc_irq_r && result_r == $past(conv_i.data))
        else $error("single conversion gave no interrupt");

    chk_ref_tracks: assert property ( // [R12]
        adc_irq_r |-> ref_r == result_r)
        else $error("reference not updated on interrupt");

    chk_bg_off: assert property ( // [R3]
        interval_r == evc_pkg::INTERVAL_OFF && !go_r |=> !conv_start_o)
        else $error("background ran with zero interval");

    chk_flag_set: assert property ( // [R4]
        s_bg_change |=> flag_r && adc_irq_r)
        else $error("change flag not set");

    chk_psm_route: assert property ( // [R5]
        flag_r && en_r |=> psm_irq_o)
        else $error("power interrupt not raised");

    chk_psm_quiet: assert property ( // [R5]
        !(flag_r && en_r) |=> !psm_irq_o)
        else $error("power interrupt without enabled flag");

    chk_batt_no_bg: assert property ( // [R7]
        batt_act && !go_r |=> !conv_start_o)
        else $error("background ran on battery");

    chk_sleep_no_go: assert property ( // [R8]
        deep_slp && !go_r |=> !go_r)
        else $error("single start accepted in deep sleep");

    chk_full_go: assert property ( // [R6]
        full_pwr && wr_start && wd[evc_pkg::GO_BIT] |=> go_r)
        else $error("single start dropped at full power");

    chk_irq_cause: assert property ( // [R10]
        adc_irq_r |-> $past(done))
        else $error("interrupt without conversion");

    chk_launch_pulse: assert property ( // [R2]
        launch_single |=> conv_start_o ##1 !conv_start_o)
        else $error("start pulse malformed");
endmodule

`default_nettype wire

// ==== evc_pkg.sv ====
package evc_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [7:0] ADDR_START = 8'hD8;
    localparam logic [7:0] ADDR_RESULT = 8'hEF;
    localparam logic [7:0] ADDR_DELTA = 8'hF3;
    localparam logic [7:0] ADDR_PM_FLAG = 8'hF8;
    localparam logic [7:0] ADDR_PM_EN = 8'hEC;
    localparam logic [7:0] ADDR_STROBE = 8'hF9;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int GO_BIT = 2;
    localparam int INTERVAL_LSB = 4;
    localparam int INTERVAL_W = 2;
    localparam int DELTA_LSB = 0;
    localparam int DELTA_W = 3;
    localparam int CHANGE_BIT = 3;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
    localparam logic [INTERVAL_W-1:0] INTERVAL_OFF = 2'h0;
    localparam logic [DELTA_W-1:0] DELTA_RST = 3'h0;

    // One code of the result equals this many microvolts
    localparam int LSB_UV = 15300;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int STROBE_UNIT_NS = 1000000;
    localparam int STROBE_UNIT_CYCLES = STROBE_UNIT_NS / CLK_PERIOD_NS;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        FULL_POWER_STATE,
        BATTERY_ACTIVE_STATE,
        DEEP_SLEEP_STATE
    } evc_pwr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } evc_sfr_req_t;

    typedef struct packed {
        logic done;
        logic [DATA_W-1:0] data;
    } evc_conv_t;

endpackage

// ==== evc_strobe_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module evc_strobe_timer #(
    parameter int unsigned UNIT_CYCLES = evc_pkg::STROBE_UNIT_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic nrst_i, // Sync reset, active low
    input wire logic [evc_pkg::INTERVAL_W-1:0] interval_i, // Units
    output logic tick_o // One-cycle strobe
);
    localparam int CW = $clog2(UNIT_CYCLES + 1);

    logic [CW-1:0] pre_r;
    logic [evc_pkg::INTERVAL_W-1:0] units_r;
    logic tick_r;

    wire running = interval_i != evc_pkg::INTERVAL_OFF;
    wire unit_end = pre_r == CW'(UNIT_CYCLES - 1);
    wire period_end = unit_end && (units_r == interval_i - 2'h1);

    always_ff @(posedge clk_i) begin
        if (!nrst_i || !running) begin
            pre_r <= '0;
            units_r <= '0;
            tick_r <= 1'h0;
        end else begin
            pre_r <= unit_end ? '0 : pre_r + CW'(1);
            units_r <= period_end ? '0 : units_r + 2'(unit_end);
            tick_r <= period_end;
        end
    end

    assign tick_o = tick_r;
endmodule

`default_nettype wire

// ==== evc_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module evc_ctrl_tb;

    // ********************************************************
    // Stimulus and converter stand-in
    // ********************************************************
    logic clk_i;
    logic nrst_i = 1'h0;
    evc_pkg::evc_sfr_req_t req = '0;
    evc_pkg::evc_pwr_state_t pwr = evc_pkg::FULL_POWER_STATE;
    evc_pkg::evc_conv_t conv = '0;
    logic [7:0] rdata;
    logic start;
    logic irq;
    logic psm;
    logic [7:0] cdata = 8'h00;
    logic [7:0] ref_v = 8'h00;
    logic [7:0] d;
    logic [2:0] delta;
    logic exp;
    logic [1:0] lat = 2'h0;
    logic [31:0] seed = 32'h000135F2;
    int starts = 0;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    evc_ctrl #(.UNIT_CYCLES(4)) evc_ctrl_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .sfr_req_i(req),
        .sfr_rdata_o(rdata), .pwr_state_i(pwr), .conv_start_o(start),
        .conv_i(conv), .adc_irq_o(irq), .psm_irq_o(psm)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Answers every start after a fixed latency with the current sample
    always @(posedge clk_i) begin
        if (lat != 2'h0) lat <= lat - 2'h1;
        if (start) begin
            lat <= 2'h3;
            starts <= starts + 1;
        end
        conv <= {lat == 2'h1, (lat == 2'h1) ? cdata : ~cdata};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic big(input logic [7:0] a, input logic [7:0] b);
        return ((a > b) ? a - b : b - a) > {5'h00, delta};
    endfunction

    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        req <= {2'h2, a, v};
        @(posedge clk_i);
        req <= {2'h0, a, v};
    endtask

    task automatic rchk(input string w, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req <= {2'h1, a, 8'h00};
        @(posedge clk_i);
        #1 chk(w, e, rdata);
    endtask

    // Waits out any conversion in flight so a stray one never takes new data, then waits for the next launch
    task automatic conv_chk(input logic [7:0] v, input logic e);
        int s0;
        int n;
        #1;
        while (lat != 2'h0 || start) begin
            @(posedge clk_i);
            #1;
        end
        s0 = starts;
        cdata = v;
        for (n = 0; n < 60 && starts == s0; n++) begin
            @(posedge clk_i);
            #1;
        end
        chk("launch", 8'(s0 + 1), 8'(starts));
        repeat (4) @(posedge clk_i);
        #1 chk("adc irq", {7'h00, e}, {7'h00, irq});
        if (e) ref_v = v;
        rchk("result", evc_pkg::ADDR_RESULT, ref_v);
    endtask

    task automatic idle_chk(input int n);
        int s0;
        s0 = starts;
        repeat (n) @(posedge clk_i);
        #1 chk("starts", 8'(s0), 8'(starts));
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'h1;
        #1 chk("outputs", 8'h00, {5'h00, start, irq, psm});
        wr(evc_pkg::ADDR_RESULT, 8'h5A);
        wr(8'h00, 8'hFF);
        rchk("unmapped", 8'h00, 8'h00);
        rchk("result", evc_pkg::ADDR_RESULT, 8'h00);
        idle_chk(30);
        d = rnd();
        wr(evc_pkg::ADDR_START, 8'h04);
        conv_chk({2'h1, d[5:0]}, 1'h1);
        d = rnd();
        delta = d[2:0];
        wr(evc_pkg::ADDR_DELTA, {5'h00, delta});
        wr(evc_pkg::ADDR_PM_EN, 8'h08);
        wr(evc_pkg::ADDR_STROBE, 8'h10);
        rchk("delta", evc_pkg::ADDR_DELTA, {5'h00, delta});
        rchk("interval", evc_pkg::ADDR_STROBE, 8'h10);
        for (int i = 0; i < 12; i++) begin
            d = rnd();
            if (i == 0) d = ref_v + {5'h00, delta};
            if (i == 1) d = ref_v - {5'h00, delta};
            if (i == 2) d = ref_v - {5'h00, delta} - 8'h01;
            if (i == 3) d = ref_v + {5'h00, delta} + 8'h01;
            exp = big(d, ref_v);
            conv_chk(d, exp);
            rchk("flag", evc_pkg::ADDR_PM_FLAG, {4'h0, exp, 3'h0});
            chk("psm irq", {7'h00, exp}, {7'h00, psm});
            wr(evc_pkg::ADDR_PM_FLAG, 8'h00);
        end
        wr(evc_pkg::ADDR_PM_EN, 8'h00);
        conv_chk(ref_v ^ 8'h80, 1'h1);
        chk("psm masked", 8'h00, {7'h00, psm});
        wr(evc_pkg::ADDR_PM_FLAG, 8'h00);
        pwr <= evc_pkg::BATTERY_ACTIVE_STATE;
        wr(evc_pkg::ADDR_PM_FLAG, 8'h00);
        idle_chk(30);
        wr(evc_pkg::ADDR_START, 8'h04);
        conv_chk(rnd(), 1'h1);
        wr(evc_pkg::ADDR_STROBE, 8'h00);
        pwr <= evc_pkg::DEEP_SLEEP_STATE;
        wr(evc_pkg::ADDR_START, 8'h04);
        rchk("start bit", evc_pkg::ADDR_START, 8'h00);
        idle_chk(30);
        wr(evc_pkg::ADDR_STROBE, 8'h30);
        d = ~ref_v;
        conv_chk(d, big(d, ref_v));
        wr(evc_pkg::ADDR_STROBE, 8'h00);
        pwr <= evc_pkg::FULL_POWER_STATE;
        wr(evc_pkg::ADDR_START, 8'h04);
        conv_chk(ref_v, 1'h1);
        results();
    end

endmodule

`default_nettype wire
